// >>> pmdb_bank.sv
// Peripheral module disable bank with an AXI4-Lite register slave
// Behaviour
// - Bit 7 of system register set stops full-rate peripheral clock network.
// - Only the full-rate clock is gated; the divided-by-four clock runs on.
// - System bit 6 holds the fixed voltage reference disabled.
// - System bit 5 holds the voltage detector disabled.
// - System bit 4 holds the checksum unit disabled.
// - System bit 3 holds the memory scanner disabled.
// - System bit 1 holds the clock reference output disabled.
// - System bit 0 holds the pin change interrupt logic disabled.
// - Timer register bit 7 holds the measurement timer disabled.
// - Timer register bits 0 to 6 each disable the timer of that index.
// - Analog register bit 7 holds active clock tuning disabled.
// - Analog register bit 6 holds the DAC disabled.
// - Analog register bit 5 holds the ADC disabled.
// - Analog register bits 2 and 1 disable comparators two and one.
// - Analog bit 0 disables zero-cross, qualified by its configuration input.
// - Waveform register bits 6, 5, 4 disable waveform generators 3, 2, 1.
// - Waveform register bit 3 holds the signal modulator disabled.
// - Waveform register bits 2, 1, 0 disable oscillators 3, 2, 1.
// - After reset every disable bit is zero, all modules enabled.
// - Disabled module is held in reset, outputs off, its registers blocked.
// - Clearing a bit re-enables the module from its reset state.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pmdb_bank
  import pmdb_pkg::*;
(
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic zcdConfigEn, // Zero-cross config lets the disable bit act
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic sysClockNetOff, // Gate request for full-rate peripheral clock
  output pmdb_off_t modOff // Hold-in-reset requests per peripheral
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and write channel state
  logic [7:0] sysDis_r;
  logic [7:0] tmrDis_r;
  logic [7:0] anaDis_r;
  logic [7:0] wavDis_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic doWrite;
  logic wrHit;
  logic [11:0] wrIdx;
  logic [11:0] rdIdx;

  // Handshake readies from holding state
  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Word indices from byte addresses
  assign wrIdx = awAddr_r[ADDR_W-1:2];
  assign rdIdx = s_axi_araddr[ADDR_W-1:2];
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign wrHit = (wrIdx == IDX_SYSTEM) || (wrIdx == IDX_TIMER) ||
                 (wrIdx == IDX_ANALOG) || (wrIdx == IDX_WAVE);

  ////////////////////////////////////////////////////////////////////////
  // Write address capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  // Write response, error on unmapped word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Disable registers, masked to implemented bits
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sysDis_r <= RST_VAL;
      tmrDis_r <= RST_VAL;
      anaDis_r <= RST_VAL;
      wavDis_r <= RST_VAL;
    end else if (doWrite && wStrb_r[0]) begin
      if (wrIdx == IDX_SYSTEM) begin
        sysDis_r <= wData_r[7:0] & MASK_SYSTEM;
      end
      if (wrIdx == IDX_TIMER) begin
        tmrDis_r <= wData_r[7:0] & MASK_TIMER;
      end
      if (wrIdx == IDX_ANALOG) begin
        anaDis_r <= wData_r[7:0] & MASK_ANALOG;
      end
      if (wrIdx == IDX_WAVE) begin
        wavDis_r <= wData_r[7:0] & MASK_WAVE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel, one-cycle answer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r <= RESP_OKAY;
      case (rdIdx)
        IDX_SYSTEM: rData_r <= {24'h000000, sysDis_r};
        IDX_TIMER: rData_r <= {24'h000000, tmrDis_r};
        IDX_ANALOG: rData_r <= {24'h000000, anaDis_r};
        IDX_WAVE: rData_r <= {24'h000000, wavDis_r};
        default: begin
          rData_r <= '0;
          rResp_r <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered disable requests; peripherals hold reset and block access
  // while high and restart from reset values when low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sysClockNetOff <= 1'b0;
      modOff <= '0;
    end else begin
      sysClockNetOff <= sysDis_r[B_SYSCLK];
      modOff.fixedVrefOff <= sysDis_r[B_FVREF];
      modOff.voltDetectOff <= sysDis_r[B_VDET];
      modOff.checksumUnitOff <= sysDis_r[B_CRC];
      modOff.memScannerOff <= sysDis_r[B_SCAN];
      modOff.clockRefOutOff <= sysDis_r[B_CLKREF];
      modOff.pinChangeIrqOff <= sysDis_r[B_IOC];
      modOff.measureTimerOff <= tmrDis_r[B_MTMR];
      modOff.timerNOff <= tmrDis_r[N_TIMERS-1:0];
      modOff.activeTuningOff <= anaDis_r[B_ACT];
      modOff.dacUnitOff <= anaDis_r[B_DAC];
      modOff.adcUnitOff <= anaDis_r[B_ADC];
      modOff.comparatorTwoOff <= anaDis_r[B_CMP2];
      modOff.comparatorOneOff <= anaDis_r[B_CMP1];
      modOff.zeroCrossOff <= anaDis_r[B_ZCD] && zcdConfigEn;
      modOff.waveformGen3Off <= wavDis_r[B_CWG3];
      modOff.waveformGen2Off <= wavDis_r[B_CWG2];
      modOff.waveformGen1Off <= wavDis_r[B_CWG1];
      modOff.signalModulatorOff <= wavDis_r[B_DSM];
      modOff.ctrlOsc3Off <= wavDis_r[B_NCO3];
      modOff.ctrlOsc2Off <= wavDis_r[B_NCO2];
      modOff.ctrlOsc1Off <= wavDis_r[B_NCO1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the system register outputs
  // Each output is its register bit, one edge later
  // Clock network gate follows its bit
  a_sysclk_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sysClockNetOff == $past(sysDis_r[B_SYSCLK]))
    else $error("clock gate lag wrong");
  // Voltage reference off follows its bit
  a_fvref_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.fixedVrefOff == $past(sysDis_r[B_FVREF]))
    else $error("vref off wrong");
  // Voltage detector off follows its bit
  a_vdet_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.voltDetectOff == $past(sysDis_r[B_VDET]))
    else $error("vdet off wrong");
  // Checksum unit off follows its bit
  a_crc_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.checksumUnitOff == $past(sysDis_r[B_CRC]))
    else $error("checksum off wrong");
  // Memory scanner off follows its bit
  a_scan_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.memScannerOff == $past(sysDis_r[B_SCAN]))
    else $error("scanner off wrong");
  // Clock reference output off follows its bit
  a_clkref_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.clockRefOutOff == $past(sysDis_r[B_CLKREF]))
    else $error("clock ref off wrong");
  // Pin change logic off follows its bit
  a_ioc_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.pinChangeIrqOff == $past(sysDis_r[B_IOC]))
    else $error("pin change off wrong");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the timer and analog register outputs
  // Measurement timer off follows its bit
  a_mtmr_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.measureTimerOff == $past(tmrDis_r[B_MTMR]))
    else $error("measure timer off wrong");
  // Timer offs follow their bits
  a_timer_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.timerNOff == $past(tmrDis_r[N_TIMERS-1:0]))
    else $error("timer off wrong");
  // Clock tuning off follows its bit
  a_act_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.activeTuningOff == $past(anaDis_r[B_ACT]))
    else $error("tuning off wrong");
  // Converter off rises one edge after its bit
  a_dac_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(anaDis_r[B_DAC]) |=> modOff.dacUnitOff)
    else $error("dac off late");
  // Converter off level follows its bit
  a_dac_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.dacUnitOff == $past(anaDis_r[B_DAC]))
    else $error("dac off wrong");
  // Sampling converter off follows its bit
  a_adc_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.adcUnitOff == $past(anaDis_r[B_ADC]))
    else $error("adc off wrong");
  // Comparator two released after its bit falls
  a_cmp_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(anaDis_r[B_CMP2]) |=> !modOff.comparatorTwoOff)
    else $error("cmp2 stuck off");
  // Comparator one off follows its bit
  a_cmp1_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.comparatorOneOff == $past(anaDis_r[B_CMP1]))
    else $error("cmp1 off wrong");
  // Zero-cross off only while configuration allows it
  a_zcd_qualify: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.zeroCrossOff |-> $past(zcdConfigEn))
    else $error("zcd off unqualified");
  // Zero-cross off is bit and configuration together
  a_zcd_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.zeroCrossOff == $past(anaDis_r[B_ZCD] && zcdConfigEn))
    else $error("zcd off wrong");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the waveform register outputs
  // Generator three off follows its bit
  a_cwg3_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.waveformGen3Off == $past(wavDis_r[B_CWG3]))
    else $error("gen3 off wrong");
  // Generator two off follows its bit
  a_cwg2_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.waveformGen2Off == $past(wavDis_r[B_CWG2]))
    else $error("gen2 off wrong");
  // Generator one off follows its bit
  a_cwg1_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.waveformGen1Off == $past(wavDis_r[B_CWG1]))
    else $error("gen1 off wrong");
  // Signal modulator off follows its bit
  a_dsm_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.signalModulatorOff == $past(wavDis_r[B_DSM]))
    else $error("modulator off wrong");
  // Oscillator three off follows its bit
  a_nco3_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.ctrlOsc3Off == $past(wavDis_r[B_NCO3]))
    else $error("osc3 off wrong");
  // Oscillator two off follows its bit
  a_nco2_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    modOff.ctrlOsc2Off == $past(wavDis_r[B_NCO2]))
    else $error("osc2 off wrong");

  ////////////////////////////////////////////////////////////////////////
  // Checks on reset, masking and write timing
  // Reserved positions never hold a one
  a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sysDis_r[2] == 1'b0) && (anaDis_r[4:3] == 2'b00) && (wavDis_r[7] == 1'b0))
    else $error("unimplemented bit set");
  // Reset clears every disable register
  a_reset_clear: assert property (@(posedge clk_sys)
    !rst_n |=> (sysDis_r == 8'h00 && tmrDis_r == 8'h00 && anaDis_r == 8'h00 && wavDis_r == 8'h00))
    else $error("reset left bits set");
  // Reset clears every disable output
  a_outputs_reset: assert property (@(posedge clk_sys)
    !rst_n |=> (!sysClockNetOff && modOff == '0))
    else $error("reset left outputs set");
  // A waveform write reaches its output two edges on
  a_write_reach: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && wStrb_r[0] && wrIdx == IDX_WAVE) |-> ##2 (modOff.ctrlOsc1Off == $past(wData_r[B_NCO1], 2)))
    else $error("write not effective");
  // System write lands masked one edge on
  a_write_system: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && wStrb_r[0] && wrIdx == IDX_SYSTEM) |=> (sysDis_r == ($past(wData_r[7:0]) & MASK_SYSTEM)))
    else $error("system write wrong");
  // Analog write lands masked one edge on
  a_write_analog: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && wStrb_r[0] && wrIdx == IDX_ANALOG) |=> (anaDis_r == ($past(wData_r[7:0]) & MASK_ANALOG)))
    else $error("analog write wrong");
  // Low byte strobe off leaves every register alone
  a_strobe_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && !wStrb_r[0]) |=> ($stable(sysDis_r) && $stable(tmrDis_r) && $stable(anaDis_r) && $stable(wavDis_r)))
    else $error("masked write changed a register");

  ////////////////////////////////////////////////////////////////////////
  // Checks on the register bus answers
  // Write answer one edge after both halves are held
  a_write_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    doWrite |=> s_axi_bvalid)
    else $error("write answer late");
  // Unmapped word answers with an error
  a_bresp_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (doWrite && !wrHit) |=> (s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  // Accepted write answer drops
  a_bvalid_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write answer stuck");
  // No new write taken while an answer is pending
  a_busy_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while busy");
  // Read answer one edge after the address is taken
  a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  // Upper read bits are always zero
  a_read_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
    else $error("upper read bits set");

endmodule : pmdb_bank
`default_nettype wire

// >>> pmdb_pkg.sv
// Package for the peripheral module disable bank: offsets, masks, carriers
package pmdb_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [11:0] IDX_SYSTEM = 12'h060;
  localparam logic [11:0] IDX_TIMER = 12'h061;
  localparam logic [11:0] IDX_ANALOG = 12'h063;
  localparam logic [11:0] IDX_WAVE = 12'h064;
  localparam int ADDR_W = 14;
  // Implemented bit masks
  localparam logic [7:0] MASK_SYSTEM = 8'hfb;
  localparam logic [7:0] MASK_TIMER = 8'hff;
  localparam logic [7:0] MASK_ANALOG = 8'he7;
  localparam logic [7:0] MASK_WAVE = 8'h7f;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Field positions
  localparam int B_SYSCLK = 7;
  localparam int B_FVREF = 6;
  localparam int B_VDET = 5;
  localparam int B_CRC = 4;
  localparam int B_SCAN = 3;
  localparam int B_CLKREF = 1;
  localparam int B_IOC = 0;
  localparam int B_MTMR = 7;
  localparam int N_TIMERS = 7;
  localparam int B_ACT = 7;
  localparam int B_DAC = 6;
  localparam int B_ADC = 5;
  localparam int B_CMP2 = 2;
  localparam int B_CMP1 = 1;
  localparam int B_ZCD = 0;
  localparam int B_CWG3 = 6;
  localparam int B_CWG2 = 5;
  localparam int B_CWG1 = 4;
  localparam int B_DSM = 3;
  localparam int B_NCO3 = 2;
  localparam int B_NCO2 = 1;
  localparam int B_NCO1 = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Hold-in-reset requests to each peripheral
  typedef struct packed {
    logic fixedVrefOff;
    logic voltDetectOff;
    logic checksumUnitOff;
    logic memScannerOff;
    logic clockRefOutOff;
    logic pinChangeIrqOff;
    logic measureTimerOff;
    logic [N_TIMERS-1:0] timerNOff;
    logic activeTuningOff;
    logic dacUnitOff;
    logic adcUnitOff;
    logic comparatorTwoOff;
    logic comparatorOneOff;
    logic zeroCrossOff;
    logic waveformGen3Off;
    logic waveformGen2Off;
    logic waveformGen1Off;
    logic signalModulatorOff;
    logic ctrlOsc3Off;
    logic ctrlOsc2Off;
    logic ctrlOsc1Off;
  } pmdb_off_t;
endpackage : pmdb_pkg

// >>> tb.sv
// Self-checking testbench for the peripheral module disable bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmdb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic zcdConfigEn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic sysClockNetOff;
  pmdb_off_t modOff;
  int fails = 0;
  int samples_checked = 0;
  logic [15:0] lfsrR = 16'heeb0;
  logic [7:0] regModel [4];
  logic [ADDR_W-1:0] regAddr [4];
  logic [7:0] regMask [4];
  logic [3:0] strbUse = 4'hf;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  always #50 clk_sys = ~clk_sys;

  pmdb_bank pmdb_bank_inst (.clk_sys(clk_sys), .rst_n(rst_n), .zcdConfigEn(zcdConfigEn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sysClockNetOff(sysClockNetOff),
    .modOff(modOff));

  ////////////////////////////////////////////////////////////////////////////////
  // Random source and expected outputs
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic pmdb_off_t exp_off(input logic [7:0] s, t, a, w, input logic z);
    return pmdb_off_t'({s[6:3], s[1:0], t, a[7:5], a[2:1], a[0] & z, w[6:0]});
  endfunction : exp_off

  // Comparison, verdict and timeout
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic hang_cut();
    fails++;
    $display("ERROR at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask : hang_cut

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: readies sampled at the falling edge, taken at the next rise
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, wt, done;
    int n;
    done = 0;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strbUse;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk_sys);
      aw = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!done) hang_cut();
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, done;
    int n;
    done = 0;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk_sys);
      ar = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!done) hang_cut();
  endtask : axi_read

  ////////////////////////////////////////////////////////////////////////////////
  // Reset, then readback of every register and every disable output
  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) regModel[i] = 8'h00;
  endtask : do_reset

  task automatic verify_all();
    logic [31:0] d;
    logic [1:0] r;
    pmdb_off_t e;
    for (int i = 0; i < 4; i++) begin
      axi_read(regAddr[i], d, r);
      check(d, {24'h0, regModel[i]});
      check(32'(r), 32'(RESP_OKAY));
    end
    @(negedge clk_sys);
    e = exp_off(regModel[0], regModel[1], regModel[2], regModel[3], zcdConfigEn);
    check(32'(sysClockNetOff), 32'(regModel[0][7]));
    check(32'(modOff[26:13]), 32'(e[26:13]));
    check(32'(modOff[12:0]), 32'(e[12:0]));
  endtask : verify_all

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: all ones, all zeros, then random values
  initial begin
    int i;
    logic [31:0] d;
    logic [1:0] r;
    regAddr = '{{IDX_SYSTEM, 2'b00}, {IDX_TIMER, 2'b00}, {IDX_ANALOG, 2'b00}, {IDX_WAVE, 2'b00}};
    regMask = '{MASK_SYSTEM, MASK_TIMER, MASK_ANALOG, MASK_WAVE};
    do_reset();
    verify_all();
    $display("test reset values done");
    for (int k = 0; k < 32; k++) begin
      i = k % 4;
      lfsrR = lfsr_next(lfsrR);
      d = (k < 4) ? 32'hffffffff : (k < 8) ? 32'h0 : {lfsrR, lfsr_next(lfsrR)};
      @(posedge clk_sys);
      zcdConfigEn <= (k < 8) ? 1'b1 : lfsrR[3];
      axi_write(regAddr[i], d, r);
      check(32'(r), 32'(RESP_OKAY));
      regModel[i] = d[7:0] & regMask[i];
      repeat (8) @(posedge clk_sys); // Two instruction cycles before touching a module
      verify_all();
    end
    $display("test register writes done");
    axi_write({12'h062, 2'b00}, 32'hffffffff, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_read({12'h062, 2'b00}, d, r);
    check(d, 32'h0);
    check(32'(r), 32'(RESP_SLVERR));
    verify_all();
    $display("test unmapped word done");
    strbUse = 4'he;
    axi_write(regAddr[3], 32'hffffffff, r);
    strbUse = 4'hf;
    check(32'(r), 32'(RESP_OKAY));
    verify_all();
    $display("test strobe off done");
    do_reset();
    verify_all();
    $display("test second reset done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
